//--- rtl/dyn_can_engine.sv
`include "dyn_can_defines.svh"

// ----------------------------------------
// frame fifo
// ----------------------------------------
module frame_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wrPtr_r;
   logic [AW:0]  rdPtr_r;
   logic         push;
   logic         pop;

   // full and empty from pointer wrap bit
   assign inReady  = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
   assign outValid = (wrPtr_r != rdPtr_r);
   assign outData  = mem[rdPtr_r[AW-1:0]];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // storage
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   // pointers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------
// dynamic produce / consume engine
// ----------------------------------------
module dyn_can_engine
   import dyn_can_pkg::*;
#(
   parameter int MS_CYC = `T_MS_NS / `CLK_NS
) (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        fbOnline,
   output logic             txFrmValid,
   input  wire logic        txFrmReady,
   output logic             txFrmExt,
   output logic [28:0]      txFrmId,
   output logic             txFrmRtr,
   output logic [3:0]       txFrmLen,
   output logic [63:0]      txFrmData,
   input  wire logic        txDone,
   input  wire logic        rxFrmValid,
   input  wire logic        rxFrmExt,
   input  wire logic [28:0] rxFrmId,
   input  wire logic [3:0]  rxFrmLen,
   input  wire logic [63:0] rxFrmData
);
   logic [15:0] ctrl_r;
   logic [31:0] txId_r, txPar_r, txDat0_r, txDat1_r;
   logic [31:0] rxId_r, rxPar_r, rxDat0_r, rxDat1_r;
   logic [7:0]  trig_r, txCnt_r, rxCnt_r;
   logic [2:0]  stat_r;
   logic        ack_r;
   logic [31:0] dat_r;
   logic        fbSync1_r, fbSync2_r;
   logic [17:0] msCnt_r;
   logic        msTick;
   logic [15:0] cycCnt_r, toCnt_r;
   logic        pend_r;
   logic        shotArm_r;
   logic        wr;
   logic [31:0] wrVal;
   logic        fbOff;
   tx_off_t     txOff;
   upd_mode_t   mode;
   logic        fifoInReady;
   logic        push;
   logic [3:0]  txLen;
   logic [15:0] updTime, toTime;
   logic        rxHit;
   logic        rxErr;
   logic [`FRM_W-1:0] frmIn, frmOut;

   // byte-lane merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nv[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // length limited to the largest object
   function automatic logic [3:0] clampLen(input logic [3:0] l);
      return (l > `MAX_LEN) ? `MAX_LEN : l;
   endfunction

   // parameter word with its length field limited, so readback never exceeds the maximum
   function automatic logic [31:0] clampPar(input logic [31:0] p);
      logic [31:0] r;
      r = p;
      r[`P_LEN] = clampLen(p[`P_LEN]);
      return r;
   endfunction

   // raise a nonzero time to its least legal value
   function automatic logic [15:0] floorTime(input logic [15:0] t, input logic [15:0] m);
      return (t != 16'h0000 && t < m) ? m : t;
   endfunction

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   assign wr    = cyc_i & stb_i & we_i & ~ack_r;
   assign ack_o = ack_r;
   assign dat_o = dat_r;
   assign mode  = upd_mode_t'(ctrl_r[`C_MODE]);
   assign txOff = tx_off_t'(ctrl_r[`C_TXOFF]);
   assign fbOff = ~fbSync2_r;

   // answer one cycle after the request
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= cyc_i & stb_i & ~ack_r;
      end
   end

   // read mux, unmapped reads zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dat_r <= 32'h00000000;
      end else if (cyc_i & stb_i & ~we_i & ~ack_r) begin
         unique case (adr_i)
            `A_CTRL:   dat_r <= {16'h0000, ctrl_r};
            `A_TXID:   dat_r <= txId_r;
            `A_TXPAR:  dat_r <= txPar_r;
            `A_TXDAT0: dat_r <= txDat0_r;
            `A_TXDAT1: dat_r <= txDat1_r;
            `A_TRIG:   dat_r <= {16'h0000, txCnt_r, trig_r};
            `A_RXID:   dat_r <= rxId_r;
            `A_RXPAR:  dat_r <= rxPar_r;
            `A_RXDAT0: dat_r <= rxDat0_r;
            `A_RXDAT1: dat_r <= rxDat1_r;
            `A_RXSTAT: dat_r <= {16'h0000, rxCnt_r, 5'h00, stat_r};
            default:   dat_r <= 32'h00000000;
         endcase
      end
   end

   // parameter blocks, reserved bits kept zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r  <= 16'h0000;
         txId_r  <= 32'h00000000;
         txPar_r <= 32'h00000000;
         rxId_r  <= 32'h00000000;
         rxPar_r <= 32'h00000000;
         trig_r  <= 8'h00;
      end else if (wr) begin
         unique case (adr_i)
            `A_CTRL:  ctrl_r  <= 16'(merge({16'h0000, ctrl_r}, dat_i, sel_i) & 32'h000003ff);
            `A_TXID:  txId_r  <= merge(txId_r, dat_i, sel_i) & 32'h1fffffff;
            `A_TXPAR: txPar_r <= clampPar(merge(txPar_r, dat_i, sel_i) & 32'h001fffff);
            `A_RXID:  rxId_r  <= merge(rxId_r, dat_i, sel_i) & 32'h1fffffff;
            `A_RXPAR: rxPar_r <= clampPar(merge(rxPar_r, dat_i, sel_i) & 32'h000fffff);
            `A_TRIG:  trig_r  <= sel_i[0] ? dat_i[7:0] : trig_r;
            default: ;
         endcase
      end
   end

   // output data; frozen while the fieldbus is offline in OFF_FREEZE mode
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         txDat0_r <= 32'h00000000;
         txDat1_r <= 32'h00000000;
      end else if (wr & ~(fbOff & txOff == OFF_FREEZE)) begin
         if (adr_i == `A_TXDAT0) begin
            txDat0_r <= merge(txDat0_r, dat_i, sel_i);
         end
         if (adr_i == `A_TXDAT1) begin
            txDat1_r <= merge(txDat1_r, dat_i, sel_i);
         end
      end
   end

   // ----------------------------------------
   // fieldbus state and millisecond tick
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fbSync1_r <= 1'b0;
         fbSync2_r <= 1'b0;
      end else begin
         fbSync1_r <= fbOnline;
         fbSync2_r <= fbSync1_r;
      end
   end

   assign msTick = (msCnt_r == 18'(MS_CYC - 1));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         msCnt_r <= 18'h00000;
      end else begin
         msCnt_r <= msTick ? 18'h00000 : msCnt_r + 18'h00001;
      end
   end

   // ----------------------------------------
   // transmit triggering
   // ----------------------------------------
   assign updTime = floorTime(txPar_r[`P_TIME], `MIN_UPD);
   assign txLen   = clampLen(txPar_r[`P_LEN]);
   assign push    = pend_r & fifoInReady & ~(fbOff & txOff == OFF_STOP);

   // cyclic interval counter
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cycCnt_r <= 16'h0000;
      end else if (mode != UPD_CYCLIC || updTime == 16'h0000) begin
         cycCnt_r <= 16'h0000;
      end else if (msTick) begin
         cycCnt_r <= (cycCnt_r >= updTime - 16'h0001) ? 16'h0000 : cycCnt_r + 16'h0001;
      end
   end

   // single shot armed by a write selecting that mode
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shotArm_r <= 1'b0;
      end else begin
         shotArm_r <= wr && adr_i == `A_CTRL && sel_i[0] && dat_i[`C_MODE] == UPD_SINGLE;
      end
   end

   // pending send; a new cause wins over the push clear
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_r <= 1'b0;
      end else begin
         if (push) begin
            pend_r <= 1'b0;
         end
         if ((mode == UPD_CYCLIC && updTime != 16'h0000 && msTick
              && cycCnt_r >= updTime - 16'h0001)
             || (mode == UPD_SINGLE && shotArm_r)
             || (mode == UPD_CHANGE && wr && adr_i == `A_TXDAT0
                 && merge(txDat0_r, dat_i, sel_i) != txDat0_r)
             || (mode == UPD_CHANGE && wr && adr_i == `A_TXDAT1
                 && merge(txDat1_r, dat_i, sel_i) != txDat1_r)
             || (mode == UPD_TRIG && wr && adr_i == `A_TRIG && sel_i[0]
                 && dat_i[7:0] != trig_r)) begin
            pend_r <= 1'b1;
         end
      end
   end

   // frame image: ext, id, rtr, len, data; cleared data when offline in OFF_CLEAR mode
   assign frmIn = {ctrl_r[`C_TXEXT],
                   ctrl_r[`C_TXEXT] ? txId_r[28:0] : txId_r[28:0] & `ID11_MSK,
                   txPar_r[`P_RTR], txLen,
                   (fbOff && txOff == OFF_CLEAR) ? 64'h0 : {txDat1_r, txDat0_r}};

   // single transmit path toward the controller
   frame_fifo #(.W(`FRM_W), .D(`FIFO_D)) txFifo (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .inValid  (push),
      .inReady  (fifoInReady),
      .inData   (frmIn),
      .outValid (txFrmValid),
      .outReady (txFrmReady),
      .outData  (frmOut)
   );
   assign {txFrmExt, txFrmId, txFrmRtr, txFrmLen, txFrmData} = frmOut;

   // completion counter
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         txCnt_r <= 8'h00;
      end else if (txDone & ctrl_r[`C_TXCNT]) begin
         txCnt_r <= txCnt_r + 8'h01;
      end
   end

   // ----------------------------------------
   // receive transaction
   // ----------------------------------------
   assign toTime = floorTime(rxPar_r[`P_TIME], `MIN_TO);
   assign rxHit  = rxFrmValid && rxFrmExt == ctrl_r[`C_RXEXT]
                   && rxFrmId == (ctrl_r[`C_RXEXT] ? rxId_r[28:0] : rxId_r[28:0] & `ID11_MSK);
   assign rxErr  = rxFrmLen != clampLen(rxPar_r[`P_LEN]);

   // offline timeout in ms since last matching frame, length error or not
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         toCnt_r <= 16'h0000;
      end else if (rxHit || toTime == 16'h0000) begin
         toCnt_r <= 16'h0000;
      end else if (msTick && toCnt_r != 16'hffff) begin
         toCnt_r <= toCnt_r + 16'h0001;
      end
   end

   // status: timeout, data error, not executed
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_r <= 3'b100;
      end else if (ctrl_r[`C_STAT]) begin
         if (rxHit) begin
            stat_r[`ST_TO]   <= 1'b0;
            stat_r[`ST_DERR] <= rxErr;
            stat_r[`ST_NEX]  <= 1'b0;
         end else if (toTime != 16'h0000 && toCnt_r >= toTime) begin
            stat_r[`ST_TO] <= 1'b1;
         end
      end
   end

   // input data; cleared when the timeout marks CAN offline, unless C_RXOFF is set
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxDat0_r <= 32'h00000000;
         rxDat1_r <= 32'h00000000;
      end else if (rxHit && !rxErr) begin
         {rxDat1_r, rxDat0_r} <= rxFrmData;
      end else if (toTime != 16'h0000 && toCnt_r >= toTime && !ctrl_r[`C_RXOFF]) begin
         rxDat0_r <= 32'h00000000;
         rxDat1_r <= 32'h00000000;
      end
   end

   // reception counter
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxCnt_r <= 8'h00;
      end else if (rxHit && !rxErr && ctrl_r[`C_RXCNT]) begin
         rxCnt_r <= rxCnt_r + 8'h01;
      end
   end
endmodule

//--- rtl/dyn_can_defines.svh
`ifndef DYN_CAN_DEFINES_SVH
`define DYN_CAN_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define A_CTRL   8'h00
`define A_TXID   8'h04
`define A_TXPAR  8'h08
`define A_TXDAT0 8'h0c
`define A_TXDAT1 8'h10
`define A_TRIG   8'h14
`define A_RXID   8'h18
`define A_RXPAR  8'h1c
`define A_RXDAT0 8'h20
`define A_RXDAT1 8'h24
`define A_RXSTAT 8'h28
// ----------------------------------------
// control fields
// ----------------------------------------
`define C_MODE   1:0
`define C_TXOFF  3:2
`define C_RXOFF  4
`define C_TXCNT  5
`define C_RXCNT  6
`define C_STAT   7
`define C_TXEXT  8
`define C_RXEXT  9
// ----------------------------------------
// parameter block and status fields, limits
// ----------------------------------------
`define P_TIME   15:0
`define P_LEN    19:16
`define P_RTR    20
`define ST_TO    0
`define ST_DERR  1
`define ST_NEX   2
`define MAX_LEN  4'h8
`define MIN_UPD  16'h0005
`define MIN_TO   16'h000a
`define ID11_MSK 29'h000007ff
// ----------------------------------------
// timing and sizes
// ----------------------------------------
`define T_MS_NS  1000000
`define CLK_NS   5
`define FIFO_D   32
`define FRM_W    99
`endif

//--- rtl/dyn_can_pkg.sv
package dyn_can_pkg;
   typedef enum logic [1:0] {
      UPD_CYCLIC = 2'b00,
      UPD_CHANGE = 2'b01,
      UPD_SINGLE = 2'b10,
      UPD_TRIG   = 2'b11
   } upd_mode_t;
   typedef enum logic [1:0] {
      OFF_CLEAR  = 2'b00,
      OFF_FREEZE = 2'b01,
      OFF_STOP   = 2'b10,
      OFF_RSVD   = 2'b11
   } tx_off_t;
endpackage

//--- tb/dyn_can_chk.sv
`include "dyn_can_defines.svh"
// ----------------------------------------
// port checks of the engine
// ----------------------------------------
module dyn_can_chk #(
   parameter int MS_CYC = 20
) (
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        txFrmValid,
   input wire logic        txFrmReady,
   input wire logic        txFrmExt,
   input wire logic [28:0] txFrmId,
   input wire logic        txFrmRtr,
   input wire logic [3:0]  txFrmLen,
   input wire logic [63:0] txFrmData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   // a taken request and its single ack
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   a_bus_answer: assert property (s_take |=> s_answer)
      else $error("request not answered by one ack pulse");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   a_frame_hold: assert property (txFrmValid && !txFrmReady |=> txFrmValid &&
      $stable({txFrmExt, txFrmId, txFrmRtr, txFrmLen, txFrmData}))
      else $error("frame changed before it was taken");
   a_len_max: assert property (txFrmValid |-> txFrmLen <= `MAX_LEN)
      else $error("frame length above maximum");
   a_id_short: assert property (txFrmValid && !txFrmExt |-> txFrmId[28:11] == 18'h0)
      else $error("short identifier has upper bits");
   a_stat_rsvd: assert property (ack_o && $past(adr_i == `A_RXSTAT && !we_i)
      |-> dat_o[7:3] == 5'h0)
      else $error("status reserved bits set");
   a_txpar_rsvd: assert property (ack_o && $past(adr_i == `A_TXPAR && !we_i)
      |-> dat_o[31:21] == 11'h0 && dat_o[19:16] <= `MAX_LEN)
      else $error("transmit parameter reserved bits set");
   a_rxpar_rsvd: assert property (ack_o && $past(adr_i == `A_RXPAR && !we_i)
      |-> dat_o[31:20] == 12'h0 && dat_o[19:16] <= `MAX_LEN)
      else $error("receive parameter reserved bits set");
   a_unmapped_zero: assert property (ack_o && $past(adr_i == 8'hfc && !we_i)
      |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind dyn_can_engine dyn_can_chk #(.MS_CYC(MS_CYC)) chk_u (.ref_clk, .arst_n, .cyc_i, .stb_i,
   .we_i, .adr_i, .dat_o, .ack_o, .txFrmValid, .txFrmReady, .txFrmExt, .txFrmId, .txFrmRtr,
   .txFrmLen, .txFrmData);

//--- tb/can_node.sv
// ----------------------------------------
// can controller model
// ----------------------------------------
module can_node (
   input  wire logic   ref_clk,
   input  wire logic   stall,
   input  wire logic   txFrmValid,
   output logic        txFrmReady,
   output logic        txDone,
   output logic        rxFrmValid,
   output logic        rxFrmExt,
   output logic [28:0] rxFrmId,
   output logic [3:0]  rxFrmLen,
   output logic [63:0] rxFrmData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] doneDly;
   bit         busy = 1'b0;
   initial begin
      {txFrmReady, txDone, rxFrmValid, rxFrmExt, doneDly} = 6'h00;
      rxFrmId = 29'h0;
      rxFrmLen = 4'h0;
      rxFrmData = 64'h0;
   end
   // ready follows inverted stall; done three cycles after a take
   always @(posedge ref_clk) begin
      txFrmReady <= !stall;
      doneDly <= {doneDly[0], txFrmValid && txFrmReady};
      txDone <= doneDly[1];
   end
   // idle receive lines carry no stale frame
   always @(posedge ref_clk) begin
      if (!busy) begin
         rxFrmId <= ~rxFrmId;
         rxFrmData <= ~rxFrmData;
      end
   end
   // one received frame, valid for one cycle
   task automatic sendRx(input logic e, input logic [28:0] id, input logic [3:0] n,
                         input logic [63:0] v);
      busy = 1'b1;
      rxFrmValid <= 1'b1;
      rxFrmExt <= e;
      rxFrmId <= id;
      rxFrmLen <= n;
      rxFrmData <= v;
      @(posedge ref_clk);
      rxFrmValid <= 1'b0;
      busy = 1'b0;
   endtask
endmodule

//--- tb/tb.sv
`include "dyn_can_defines.svh"
module tb
   import dyn_can_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk, arst_n, cyc_i, stb_i, we_i, ack_o, fbOnline, stall;
   logic              txFrmValid, txFrmReady, txFrmExt, txFrmRtr, txDone, rxFrmValid, rxFrmExt;
   logic [7:0]        adr_i;
   logic [3:0]        sel_i, txFrmLen, rxFrmLen;
   logic [28:0]       txFrmId, rxFrmId;
   logic [31:0]       dat_i, dat_o, rd, v;
   logic [63:0]       txFrmData, rxFrmData, d;
   logic [`FRM_W-1:0] curFrm, e;
   logic [`FRM_W-1:0] expQ[$];
   int                n_fail = 0, compares = 0, nFrm = 0, k;
   time               lastT = 0, gap = 0;
   dyn_can_engine #(.MS_CYC(20)) dut_u (.ref_clk, .arst_n, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .fbOnline, .txFrmValid, .txFrmReady, .txFrmExt,
      .txFrmId, .txFrmRtr, .txFrmLen, .txFrmData, .txDone, .rxFrmValid, .rxFrmExt,
      .rxFrmId, .rxFrmLen, .rxFrmData);
   can_node can_u (.ref_clk, .stall, .txFrmValid, .txFrmReady, .txDone, .rxFrmValid,
      .rxFrmExt, .rxFrmId, .rxFrmLen, .rxFrmData);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkFrm(input logic [`FRM_W-1:0] got, input logic [`FRM_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t frame got %h exp %h", $time, got, exp);
      end
   endtask
   // one classic cycle, entered just after an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= x;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      chk32(n, 32'h2);
      @(posedge ref_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      wb(1'b0, a, 32'h0);
      chk32(rd, x);
   endtask
   task automatic waitN(input int c);
      int n;
      n = 0;
      while (nFrm < c && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      chk32(nFrm, c);
   endtask
   // frames taken by the controller against the model
   always @(posedge ref_clk) begin
      if (txFrmValid === 1'b1 && txFrmReady === 1'b1) begin
         e = expQ.size() > 0 ? expQ.pop_front() : curFrm;
         chkFrm({txFrmExt, txFrmId, txFrmRtr, txFrmLen, txFrmData}, e);
         nFrm++;
         gap = $time - lastT;
         lastT = $time;
      end
   end
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end
   initial begin
      {arst_n, cyc_i, stb_i, we_i, stall} = 5'h0;
      fbOnline = 1'b1;
      adr_i = 8'h00;
      sel_i = 4'hf;
      dat_i = 32'h0;
      v = $urandom(36253);
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rc(`A_CTRL, 32'h0);
      rc(`A_TXPAR, 32'h0);
      rc(`A_RXSTAT, 32'h4);
      rc(8'hfc, 32'h0);
      $display("test reset done");
      d = {$urandom, $urandom};
      wb(1'b1, `A_TXID, 32'h0000_f5a3);
      wb(1'b1, `A_TXPAR, 32'h001f_0000);
      rc(`A_TXPAR, 32'h0018_0000);
      wb(1'b1, `A_TXDAT0, d[31:0]);
      wb(1'b1, `A_TXDAT1, d[63:32]);
      curFrm = {1'b0, 29'h5a3, 1'b1, 4'h8, d};
      wb(1'b1, `A_CTRL, {30'h8, UPD_TRIG});
      wb(1'b1, `A_TRIG, 32'h1);
      waitN(1);
      wb(1'b1, `A_TRIG, 32'h1);
      rc(`A_TRIG, 32'h0000_0101);
      chk32(nFrm, 1);
      $display("test trigger done");
      wb(1'b1, `A_CTRL, {26'h2, OFF_STOP, UPD_TRIG});
      fbOnline <= 1'b0;
      repeat (2) @(posedge ref_clk);
      wb(1'b1, `A_TRIG, 32'h2);
      rc(`A_TRIG, 32'h0000_0102);
      chk32(nFrm, 1);
      fbOnline <= 1'b1;
      waitN(2);
      fbOnline <= 1'b0;
      wb(1'b1, `A_CTRL, {26'h2, OFF_CLEAR, UPD_TRIG});
      expQ.push_back({1'b0, 29'h5a3, 1'b1, 4'h8, 64'h0});
      wb(1'b1, `A_TRIG, 32'h3);
      waitN(3);
      wb(1'b1, `A_CTRL, {26'h2, OFF_FREEZE, UPD_TRIG});
      wb(1'b1, `A_TXDAT0, ~d[31:0]);
      rc(`A_TXDAT0, d[31:0]);
      expQ.push_back({1'b0, 29'h5a3, 1'b1, 4'h8, d});
      wb(1'b1, `A_TRIG, 32'h4);
      waitN(4);
      fbOnline <= 1'b1;
      $display("test offline done");
      wb(1'b1, `A_TXPAR, 32'h0008_0005);
      curFrm = {1'b0, 29'h5a3, 1'b0, 4'h8, d};
      wb(1'b1, `A_CTRL, {30'h8, UPD_CYCLIC});
      waitN(6);
      chk32(32'(gap), 32'h1f4);
      wb(1'b1, `A_TXPAR, 32'h0008_0000);
      k = nFrm;
      repeat (300) @(posedge ref_clk);
      chk32(nFrm, k);
      wb(1'b1, `A_CTRL, {30'h8, UPD_SINGLE});
      repeat (250) @(posedge ref_clk);
      chk32(nFrm, k + 1);
      $display("test cyclic single done");
      stall <= 1'b1;
      wb(1'b1, `A_CTRL, {30'h8, UPD_CHANGE});
      k = nFrm;
      for (int i = 1; i <= 40; i++) begin
         v = ($urandom & 32'hffff_ff00) | i;
         wb(1'b1, `A_TXDAT0, v);
         if (i <= 32 || i == 40) expQ.push_back({1'b0, 29'h5a3, 1'b0, 4'h8, d[63:32], v});
      end
      stall <= 1'b0;
      waitN(k + 33);
      chk32(expQ.size(), 0);
      $display("test fill drain done");
      wb(1'b1, `A_RXID, 32'h0abc_def0);
      wb(1'b1, `A_RXPAR, 32'h0008_000a);
      wb(1'b1, `A_CTRL, 32'h2c0);
      d = {$urandom, $urandom};
      can_u.sendRx(1'b1, 29'h0abcdef0, 4'h8, d);
      rc(`A_RXDAT0, d[31:0]);
      rc(`A_RXDAT1, d[63:32]);
      rc(`A_RXSTAT, 32'h0000_0100);
      can_u.sendRx(1'b1, 29'h0abcdef0, 4'h3, ~d);
      rc(`A_RXSTAT, 32'h0000_0102);
      can_u.sendRx(1'b1, 29'h0abcdef1, 4'h8, ~d);
      rc(`A_RXDAT0, d[31:0]);
      repeat (400) @(posedge ref_clk);
      wb(1'b0, `A_RXSTAT, 32'h0);
      chk32(rd & 32'h1, 32'h1);
      rc(`A_RXDAT0, 32'h0);
      wb(1'b1, `A_CTRL, 32'h0d0);
      can_u.sendRx(1'b0, 29'h000006f0, 4'h8, d);
      rc(`A_RXDAT0, d[31:0]);
      rc(`A_RXSTAT, 32'h0000_0200);
      repeat (400) @(posedge ref_clk);
      rc(`A_RXSTAT, 32'h0000_0201);
      rc(`A_RXDAT1, d[63:32]);
      $display("test receive done");
      give_verdict();
   end
endmodule
